// File: core/lcd_pkg.sv
package lcd_pkg;
   // Register indices (word index, byte address is four times this)
   localparam int unsigned CONTROL_INDEX   = 0;
   localparam int unsigned PHASE_INDEX     = 1;
   localparam int unsigned SEG_BASE_INDEX  = 2;
   localparam int unsigned PIX_BASE_INDEX  = 8;
   localparam int unsigned REG_COUNT       = 32;
   localparam int unsigned SEG_REGS        = 6;
   localparam int unsigned PIX_REGS        = 24;
   localparam int unsigned BANK_REGS       = 6;
   localparam int unsigned COMMONS         = 4;
   localparam int unsigned SEGMENTS        = 48;

   // Control register fields
   localparam int unsigned CTL_ENABLE_BIT  = 7;
   localparam int unsigned CTL_SLEEP_BIT   = 6;
   localparam int unsigned CTL_WRITE_ERROR_FLAG_BIT    = 5;
   localparam int unsigned CTL_CS_LSB      = 2;
   localparam int unsigned CTL_MUX_LSB     = 0;

   // Phase register fields
   localparam int unsigned PS_WFT_BIT      = 7;
   localparam int unsigned PS_BIAS_BIT     = 6;
   localparam int unsigned PS_ACTIVE_BIT   = 5;
   localparam int unsigned PS_WA_BIT       = 4;
   localparam int unsigned PS_PRE_LSB      = 0;
   localparam logic [7:0]  PS_WRITE_MASK   = 8'hCF;
   localparam logic [7:0]  CTL_WRITE_MASK  = 8'hCF;
   localparam logic [7:0]  REG_RESET       = 8'h00;

   // Clock source dividers
   localparam int unsigned SYS_DIVIDE      = 8192;
   localparam int unsigned OSC_DIVIDE      = 32;

   localparam logic [1:0]  CS_SYSTEM       = 2'h0;
   localparam logic [1:0]  CS_EXT_TIMER    = 2'h1;

   localparam logic [1:0]  MUX_STATIC      = 2'h0;
   localparam logic [1:0]  MUX_QUARTER     = 2'h3;
endpackage

// File: core/segment_lcd_driver_control.sv
`timescale 1ns/1ns
// How it works
// - Driver runs only while the enable bit is one.
// - In sleep, the sleep-disable bit one stops the driver.
// - Pixel write without write-allow sets error; software only clears it.
// - Control bit four is unimplemented and reads zero.
// - Clock source: system/8192, external timer/32, internal RC/32.
// - Commons select: static, half, one-third, quarter multiplex.
// - Bias bit picks half or third bias in half/third mux.
// - Waveform type: phase flips per common period or per frame.
// - Read-only active bit shows the driver really running.
// - Prescaler divides selected clock by field value plus one.
// - Thirty-two byte registers: control, phase, six enables, 24 pixels.
// - Segment-enable bit makes the pin a segment output.
// - Pixel bit one drives dark, zero leaves clear.
// - One bit per segment/common pair, one bank per common.
// - Enabled pin drives segment with digital I/O off, else general I/O.
// - Oscillator sources keep clocking in sleep; system clock does not.
module segment_lcd_driver_control
#(
   parameter int unsigned SEGMENT_COUNT = lcd_pkg::SEGMENTS
)
(
   input  wire logic                     sys_clk,      // System clock
   input  wire logic                     reset,        // Sync reset, high
   input  wire logic                     psel,         // APB select
   input  wire logic                     penable,      // APB access phase
   input  wire logic                     pwrite,       // APB direction
   input  wire logic [11:0]              paddr,        // APB byte address
   input  wire logic [31:0]              pwdata,       // APB write data
   output logic                          pready,       // APB ready
   output logic [31:0]                   prdata,       // APB read data
   output logic                          pslverr,      // APB error
   input  wire logic                     sleep_mode,   // Processor asleep
   input  wire logic                     ext_timer_osc_input, // Ext osc pin
   input  wire logic                     internal_rc_osc,     // RC osc level
   output logic                          frame_tick,   // Frame clock pulse
   output logic                          drive_phase,  // Drive polarity
   output logic [1:0]                    common_index, // Active common
   output logic [3:0]                    common_drive, // Common lines on
   output logic [SEGMENT_COUNT-1:0]      segment_drive,// Dark pixels now
   output logic [SEGMENT_COUNT-1:0]      segment_pin_mode, // 1: LCD pin
   output logic [1:0]                    bias_level,   // 0 stat,1 half,2 third
   output logic                          driver_active // Driver running
);

   ////////////////////////////////////////////////////////////////////////
   // Types and state

   localparam int unsigned SYS_DIV_W = $clog2(lcd_pkg::SYS_DIVIDE);
   localparam int unsigned OSC_DIV_W = $clog2(lcd_pkg::OSC_DIVIDE);

   typedef enum logic [2:0]
   {
      IDLE_ST   = 3'h1,
      RUN_ST    = 3'h2,
      STOPPED_ST = 3'h4
   } drive_state_type;

   typedef struct packed
   {
      logic [7:0]                         control;
      logic [7:0]                         phase;
      logic [lcd_pkg::SEG_REGS-1:0][7:0]  seg_en;
      logic [lcd_pkg::PIX_REGS-1:0][7:0]  pixels;
      drive_state_type                    mode;
      logic [SYS_DIV_W-1:0]               sys_div;
      logic [OSC_DIV_W-1:0]               osc_div;
      logic [3:0]                         pre_count;
      logic [1:0]                         com;
      logic                               phase_bit;
      logic                               tick;
      logic                               ext_meta;
      logic                               ext_sync;
      logic                               ext_last;
      logic                               rc_meta;
      logic                               rc_sync;
      logic                               rc_last;
      logic                               slp_meta;
      logic                               slp_sync;
      logic [31:0]                        rdata;
      logic                               err;
      logic [SEGMENT_COUNT-1:0]           seg_out;
   } state_type;

   state_type state;
   state_type next_state;

   // Six enable bytes serve at most 48 segment pins
   if (SEGMENT_COUNT == 0 || SEGMENT_COUNT > lcd_pkg::SEGMENTS)
   begin : bad_segment_count
      $error("SEGMENT_COUNT must be 1 to 48");
   end

   ////////////////////////////////////////////////////////////////////////
   // Combinational next state

   logic                  write_access;
   logic [4:0]            index;
   logic [1:0]            clock_source;
   logic [1:0]            mux_select;
   logic [1:0]            last_common;
   logic                  source_tick;
   logic                  source_ok;
   logic                  want_run;
   logic                  running;
   logic                  write_allowed;
   logic [7:0]            phase_view;
   logic [7:0]            pixel_byte;

   always_comb
   begin
      next_state   = state;
      write_access = psel && penable && pwrite;
      index        = paddr[6:2];
      clock_source = state.control[lcd_pkg::CTL_CS_LSB +: 2];
      mux_select   = state.control[lcd_pkg::CTL_MUX_LSB +: 2];
      last_common  = mux_select;
      running      = (state.mode == RUN_ST);
      pixel_byte   = 8'h00;

      // Pin and sleep levels pass two flops before use
      next_state.ext_meta = ext_timer_osc_input;
      next_state.ext_sync = state.ext_meta;
      next_state.ext_last = state.ext_sync;
      next_state.rc_meta  = internal_rc_osc;
      next_state.rc_sync  = state.rc_meta;
      next_state.rc_last  = state.rc_sync;
      next_state.slp_meta = sleep_mode;
      next_state.slp_sync = state.slp_meta;

      // source select
      // Oscillator edges are only seen when slower than sys_clk / 2
      if (clock_source == lcd_pkg::CS_SYSTEM)
      begin
         source_tick = 1'b1;
      end
      else if (clock_source == lcd_pkg::CS_EXT_TIMER)
      begin
         source_tick = state.ext_sync && !state.ext_last;
      end
      else
      begin
         source_tick = state.rc_sync && !state.rc_last;
      end

      source_ok = !(state.slp_sync && clock_source == lcd_pkg::CS_SYSTEM);

      want_run = state.control[lcd_pkg::CTL_ENABLE_BIT]
                 && !(state.slp_sync
                      && state.control[lcd_pkg::CTL_SLEEP_BIT])
                 && source_ok;

      // Driver state machine
      unique case (state.mode)
         IDLE_ST:
         begin
            if (want_run)
            begin
               next_state.mode = RUN_ST;
            end
         end
         RUN_ST, STOPPED_ST:
         begin
            if (!state.control[lcd_pkg::CTL_ENABLE_BIT])
            begin
               next_state.mode = IDLE_ST;
            end
            else
            begin
               next_state.mode = want_run ? RUN_ST : STOPPED_ST;
            end
         end
         default:
         begin
            next_state.mode = IDLE_ST;
         end
      endcase

      // writes allowed while the driver is not mid-frame
      write_allowed = !running || state.tick;

      // divider chain: source divide, then prescaler
      next_state.tick = 1'b0;
      if (!running)
      begin
         next_state.sys_div   = '0;
         next_state.osc_div   = '0;
         next_state.pre_count = '0;
         next_state.com       = '0;
      end
      else if (source_tick)
      begin
         if (clock_source == lcd_pkg::CS_SYSTEM)
         begin
            next_state.sys_div = state.sys_div + 1'b1;
         end
         else
         begin
            next_state.osc_div = state.osc_div + 1'b1;
         end
         if ((clock_source == lcd_pkg::CS_SYSTEM && &state.sys_div)
             || (clock_source != lcd_pkg::CS_SYSTEM && &state.osc_div))
         begin
            if (state.pre_count == state.phase[lcd_pkg::PS_PRE_LSB +: 4])
            begin
               next_state.pre_count = '0;
               next_state.tick      = 1'b1;
            end
            else
            begin
               next_state.pre_count = state.pre_count + 1'b1;
            end
         end
      end

      if (state.tick)
      begin
         if (state.com == last_common)
         begin
            next_state.com = '0;
         end
         else
         begin
            next_state.com = state.com + 1'b1;
         end
         if (!state.phase[lcd_pkg::PS_WFT_BIT] || state.com == last_common)
         begin
            next_state.phase_bit = !state.phase_bit;
         end
      end

      // pixel bank of active common drives segments
      for (int s = 0; s < SEGMENT_COUNT; s++)
      begin
         next_state.seg_out[s] = running
            && state.pixels[state.com * lcd_pkg::BANK_REGS + s / 8][s % 8];
      end

      // phase view with live status bits
      phase_view = state.phase & lcd_pkg::PS_WRITE_MASK;
      phase_view[lcd_pkg::PS_ACTIVE_BIT] = running;
      phase_view[lcd_pkg::PS_WA_BIT]     = write_allowed;

      next_state.err = 1'b0;
      if (write_access)
      begin
         if (index == 5'(lcd_pkg::CONTROL_INDEX))
         begin
            // error bit only clears, bit four stays zero
            next_state.control = (pwdata[7:0] & lcd_pkg::CTL_WRITE_MASK)
               | (state.control & pwdata[7:0]
                  & (8'h01 << lcd_pkg::CTL_WRITE_ERROR_FLAG_BIT));
         end
         else if (index == 5'(lcd_pkg::PHASE_INDEX))
         begin
            next_state.phase = pwdata[7:0] & lcd_pkg::PS_WRITE_MASK;
         end
         else if (index < 5'(lcd_pkg::PIX_BASE_INDEX))
         begin
            next_state.seg_en[index - 5'(lcd_pkg::SEG_BASE_INDEX)] =
               pwdata[7:0];
         end
         else if (write_allowed)
         begin
            next_state.pixels[index - 5'(lcd_pkg::PIX_BASE_INDEX)] =
               pwdata[7:0];
         end
      end

      // refused pixel write sets the flag, set beats clear
      if (write_access && index >= 5'(lcd_pkg::PIX_BASE_INDEX)
          && !write_allowed)
      begin
         next_state.control[lcd_pkg::CTL_WRITE_ERROR_FLAG_BIT] = 1'b1;
      end

      // Read data and out-of-window error, both captured in setup
      if (psel && !penable)
      begin
         next_state.err = (paddr[11:7] != 5'h00);
         if (index == 5'(lcd_pkg::CONTROL_INDEX))
         begin
            pixel_byte = state.control;
         end
         else if (index == 5'(lcd_pkg::PHASE_INDEX))
         begin
            pixel_byte = phase_view;
         end
         else if (index < 5'(lcd_pkg::PIX_BASE_INDEX))
         begin
            pixel_byte = state.seg_en[index - 5'(lcd_pkg::SEG_BASE_INDEX)];
         end
         else
         begin
            pixel_byte = state.pixels[index - 5'(lcd_pkg::PIX_BASE_INDEX)];
         end
         next_state.rdata = {24'h000000, pixel_byte};
      end

      if (reset)
      begin
         next_state         = '0;
         next_state.mode    = IDLE_ST;
         next_state.control = lcd_pkg::REG_RESET;
         next_state.phase   = lcd_pkg::REG_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk)
   begin
      state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Zero-wait slave: read data captured in setup, shown in access
   assign pready       = 1'b1;
   assign prdata       = state.rdata;
   assign pslverr      = state.err && psel && penable;
   assign frame_tick   = state.tick;
   assign drive_phase  = state.phase_bit;
   assign common_index = state.com;
   assign driver_active = (state.mode == RUN_ST);
   assign segment_drive = state.seg_out;

   // common lines in use; none while stopped
   always_comb
   begin
      common_drive = 4'h0;
      if (state.mode == RUN_ST)
      begin
         common_drive[state.com] = 1'b1;
      end
   end

   // bias from mux select and bias bit
   assign bias_level = (mux_select == lcd_pkg::MUX_STATIC) ? 2'h0
      : (mux_select == lcd_pkg::MUX_QUARTER
         || !state.phase[lcd_pkg::PS_BIAS_BIT]) ? 2'h2 : 2'h1;

   genvar g;
   generate
      for (g = 0; g < SEGMENT_COUNT; g++)
      begin : pin_mode
         assign segment_pin_mode[g] = state.seg_en[g / 8][g % 8];
      end
   endgenerate

endmodule

// File: test/lcd_ctrl_asserts.sv
`timescale 1ns/1ns
module lcd_ctrl_checker
#(
   parameter int unsigned SEGMENT_COUNT = 48
)
(
   input wire logic        sys_clk,      // Clock
   input wire logic        reset,        // Sync reset
   input wire logic        psel,         // Select
   input wire logic        penable,      // Access phase
   input wire logic        pwrite,       // Direction
   input wire logic [11:0] paddr,        // Byte address
   input wire logic        pready,       // Ready
   input wire logic [31:0] prdata,       // Read data
   input wire logic        pslverr,      // Error
   input wire logic        frame_tick,   // Frame pulse
   input wire logic [1:0]  common_index, // Active common
   input wire logic [3:0]  common_drive, // Common lines
   input wire logic        driver_active // Running
);
   logic read_access;

   // Completed read cycle
   assign read_access = psel && penable && !pwrite && pready;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////
   // idle commons off
   property p_idle_commons;
      !driver_active |-> common_drive == 4'h0;
   endproperty
   a_idle_commons: assert property (p_idle_commons)
      else $error("common lines driven while idle");
   property p_common_onehot;
      driver_active |-> common_drive == 4'(4'h1 << common_index);
   endproperty
   a_common_onehot: assert property (p_common_onehot)
      else $error("common lines disagree with common index");
   property p_tick_pulse;
      $rose(frame_tick) |=> !frame_tick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse)
      else $error("frame tick longer than one cycle");
   property p_slave_error;
      psel && penable |-> pslverr == (paddr[11:7] != 5'h00);
   endproperty
   a_slave_error: assert property (p_slave_error)
      else $error("bus error does not match address map");
   property p_upper_zero;
      read_access |-> prdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper read bytes not zero");
   property p_bit_four;
      read_access && paddr == 12'h000 |-> !prdata[4];
   endproperty
   a_bit_four: assert property (p_bit_four)
      else $error("control bit four read as one");
   property p_active_read;
      read_access && paddr == 12'h004 |-> prdata[5] == $past(driver_active);
   endproperty
   a_active_read: assert property (p_active_read)
      else $error("active status bit disagrees with driver");
   property p_reset_idle;
      $past(reset) |-> !driver_active && prdata == 32'h00000000;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("driver not idle after reset");
   // Main scenarios reached
   c_tick: cover property (frame_tick);
   c_error: cover property (psel && penable && pslverr);
   c_start: cover property ($rose(driver_active));
endmodule

// File: test/lcd_panel_model.sv
`timescale 1ns/1ns
module lcd_panel_model
(
   input wire logic         sys_clk,       // Clock
   input wire logic [3:0]   common_drive,  // Common lines
   input wire logic [47:0]  segment_drive, // Segment lines
   output logic [3:0][47:0] dark           // Pixels seen dark
);
   logic [3:0] last_common;

   // dark per common
   // A common must stand two cycles, so skew between lines is not a pixel
   always_ff @(posedge sys_clk)
   begin
      last_common <= common_drive;
      for (int c = 0; c < 4; c++)
         if (common_drive[c] && last_common[c])
            dark[c] <= segment_drive;
   end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam int CTL = lcd_pkg::CONTROL_INDEX;
   localparam int PHS = lcd_pkg::PHASE_INDEX;
   localparam int OSC = lcd_pkg::OSC_DIVIDE;
   logic sys_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic sleep_mode, frame_tick;
   logic ext_timer_osc_input = 1'b0;
   logic internal_rc_osc = 1'b0;
   logic drive_phase, driver_active, err_seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] common_index, bias_level;
   logic [3:0] common_drive;
   logic [47:0] segment_drive, segment_pin_mode, pins;
   logic [3:0][47:0] dark, pix;
   int failures, samples_checked, gap;
   int base [4] = '{lcd_pkg::SYS_DIVIDE, 8 * OSC, 10 * OSC, 10 * OSC};
   logic [3:0] pre [4] = '{4'h0, 4'hF, 4'h1, 4'h0};

   segment_lcd_driver_control segment_lcd_driver_control_i
   (
      .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .sleep_mode, .ext_timer_osc_input,
      .internal_rc_osc, .frame_tick, .drive_phase, .common_index,
      .common_drive, .segment_drive, .segment_pin_mode, .bias_level,
      .driver_active
   );
   lcd_panel_model lcd_panel_model_i
   (
      .sys_clk, .common_drive, .segment_drive, .dark
   );
   ////////////////////////////////////////////////////////////
   // Clock and two slow oscillators, both stepped from sys_clk every 4 and 5 cycles
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always
   begin
      repeat (4) @(posedge sys_clk);
      ext_timer_osc_input <= ~ext_timer_osc_input;
   end
   always
   begin
      repeat (5) @(posedge sys_clk);
      internal_rc_osc <= ~internal_rc_osc;
   end
   // Watchdog sized well above the frame measurements
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      failures++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string n, input logic [47:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // One bus transfer; an idle cycle follows so no signal moves twice
   task automatic apb(input logic w, input logic [11:0] a, logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr_reg(input int i, input logic [7:0] d);
      apb(1'b1, 12'(4 * i), d);
   endtask
   task automatic expect_reg(input int i, input logic [7:0] e);
      apb(1'b0, 12'(4 * i), 8'h00);
      check($sformatf("reg %0d", i), {40'h0, e}, {16'h0, rd});
   endtask
   task automatic tick_gap(output int n);
      n = 0;
      do
         @(posedge sys_clk);
      while (frame_tick !== 1'b1);
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (frame_tick !== 1'b1);
   endtask
   task automatic wait_active(input logic v);
      for (int n = 0; n < 2000 && driver_active !== v; n++)
         @(posedge sys_clk);
      check("driver active", {47'h0, v}, {47'h0, driver_active});
   endtask
   // Sync to a frame tick, then compare the phase n ticks later
   task automatic phase_over(input int n, input logic e);
      logic ph;
      ph = 1'b0;
      for (int k = 0; k <= n; k++)
      begin
         do
            @(posedge sys_clk);
         while (frame_tick !== 1'b1);
         if (k == 0)
            ph = drive_phase;
      end
      check("drive phase", {47'h0, e ^ ph}, {47'h0, drive_phase});
   endtask
   // Commons lit over five frame ticks
   task automatic commons_seen(input int m);
      logic [3:0] seen;
      seen = 4'h0;
      repeat (5)
         do
         begin
            @(posedge sys_clk);
            seen = seen | common_drive;
         end
         while (frame_tick !== 1'b1);
      check("commons used", 48'((2 << m) - 1), {44'h0, seen});
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      {failures, samples_checked} = '0;
      {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      sleep_mode = 1'b0;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      expect_reg(CTL, 8'h00);
      expect_reg(PHS, 8'h10);
      wr_reg(CTL, 8'h7F);
      expect_reg(CTL, 8'h4F);
      wr_reg(PHS, 8'h8F);
      expect_reg(PHS, 8'h9F);
      // Segment enables, then all pins on for the glass
      for (int k = 0; k < 6; k++)
      begin
         pins[8 * k +: 8] = 8'(8'h11 * (k + 1));
         wr_reg(2 + k, pins[8 * k +: 8]);
      end
      check("pin mode", pins, segment_pin_mode);
      for (int k = 0; k < 6; k++)
         wr_reg(2 + k, 8'hFF);
      // Pixel banks, written while idle and read back
      for (int i = 0; i < 24; i++)
      begin
         pix[i / 6][8 * (i % 6) +: 8] = 8'(i * 37 + 5);
         wr_reg(8 + i, 8'(i * 37 + 5));
      end
      for (int i = 0; i < 24; i++)
         expect_reg(8 + i, pix[i / 6][8 * (i % 6) +: 8]);
      // Bias follows multiplex and bias bit
      for (int m = 0; m < 4; m++)
      begin
         wr_reg(PHS, {1'b0, m == 1, 6'h00});
         wr_reg(CTL, 8'(m));
         check("bias", 48'(m == 0 ? 0 : m == 1 ? 1 : 2),
               48'(bias_level));
      end
      // configure with the driver stopped, then enable
      for (int s = 0; s < 4; s++)
      begin
         wr_reg(CTL, 8'h03);
         wr_reg(PHS, {4'h0, pre[s]});
         wr_reg(CTL, {1'b1, 3'b000, 2'(s), 2'b11});
         tick_gap(gap);
         tick_gap(gap);
         check("frame gap", 48'(base[s] * (pre[s] + 1)),
               48'(gap));
      end
      apb(1'b0, 12'(4 * PHS), 8'h00);
      check("active bit", 48'h1, {47'h0, rd[5]});
      phase_over(1, 1'b1);
      // multiplex and waveform changed only while stopped
      for (int m = 0; m < 4; m++)
      begin
         wr_reg(CTL, 8'h0C);
         wr_reg(PHS, 8'h80);
         wr_reg(CTL, {6'h23, 2'(m)});
         commons_seen(m);
      end
      phase_over(4, 1'b1);
      repeat (2000) @(posedge sys_clk);
      for (int c = 0; c < 4; c++)
         check("dark pixels", pix[c], dark[c]);
      // Pixel write while running, clear of any frame tick, is refused
      do
         @(posedge sys_clk);
      while (frame_tick !== 1'b1);
      wr_reg(8, 8'h00);
      expect_reg(CTL, 8'hAF);
      expect_reg(8, pix[0][7:0]);
      wr_reg(CTL, 8'h8F);
      expect_reg(CTL, 8'h8F);
      // Oscillator source keeps running in sleep unless told to stop
      sleep_mode <= 1'b1;
      repeat (700) @(posedge sys_clk);
      wait_active(1'b1);
      sleep_mode <= 1'b0;
      wr_reg(CTL, 8'hCF);
      sleep_mode <= 1'b1;
      wait_active(1'b0);
      sleep_mode <= 1'b0;
      wait_active(1'b1);
      wr_reg(CTL, 8'h03);
      wait_active(1'b0);
      check("commons off", 48'h0, 48'(common_drive));
      // System clock source stops in sleep even with sleep-disable clear
      wr_reg(CTL, 8'h83);
      wait_active(1'b1);
      sleep_mode <= 1'b1;
      wait_active(1'b0);
      sleep_mode <= 1'b0;
      wait_active(1'b1);
      apb(1'b0, 12'h080, 8'h00);
      check("unmapped", 48'h1, {47'h0, err_seen});
      report_and_stop();
   end
endmodule

bind segment_lcd_driver_control lcd_ctrl_checker
#(
   .SEGMENT_COUNT(SEGMENT_COUNT)
)
lcd_ctrl_checker_i
(
   .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
   .pslverr, .frame_tick, .common_index, .common_drive, .driver_active
);
